// File: tw_regs.vh
// Register map, field positions, status codes and timing for the
// two-wire master transmitter. Included by the master design file only.
`ifndef TW_REGS_VH
`define TW_REGS_VH

// Register indices on the plain register port
`define TW_ADDR_CTRL 2'h0
`define TW_ADDR_STAT 2'h1
`define TW_ADDR_DATA 2'h2

// Control register fields
`define TW_B_FLAG 7
`define TW_B_ACK 6
`define TW_B_START 5
`define TW_B_STOP 4
`define TW_B_WCOL 3
`define TW_B_EN 2
`define TW_B_IE 0

// Reset values
`define TW_CTRL_RST 8'h00
`define TW_DATA_RST 8'hFF
`define TW_PRESC_RST 3'h0

// Status codes, prescaler bits excluded
`define TW_ST_NONE 8'hF8
`define TW_ST_START 8'h08
`define TW_ST_RSTART 8'h10
`define TW_ST_AW_ACK 8'h18
`define TW_ST_AW_NACK 8'h20
`define TW_ST_DT_ACK 8'h28
`define TW_ST_DT_NACK 8'h30
`define TW_ST_ARB 8'h38
`define TW_ST_AR_ACK 8'h40
`define TW_ST_AR_NACK 8'h48
`define TW_ST_DR_ACK 8'h50
`define TW_ST_DR_NACK 8'h58

// Operating modes shown on the mode output
`define TW_MODE_SLAVE 2'h0
`define TW_MODE_MT 2'h1
`define TW_MODE_MR 2'h2

// Half period of the serial clock, and its length in system clocks
`define TW_CLK_NS 8
`define TW_HALF_NS 5000
`define TW_HALF_CYC ((`TW_HALF_NS + `TW_CLK_NS - 1) / `TW_CLK_NS)

`endif

// File: tw_line_mon.v
// Line monitor: synchronises the two bus lines and tracks bus busy.
// Assumes raw pin levels from outside the clk domain.
`timescale 1ns/1ps
module tw_line_mon
(
  input wire clk,
  input wire rst,
  input wire scl_in,
  input wire sda_in,
  output wire scl_s,
  output wire sda_s,
  output wire bus_free
);

  reg scl_meta_reg;
  reg scl_sync_reg;
  reg sda_meta_reg;
  reg sda_sync_reg;
  reg sda_prev_reg;
  reg busy_reg;

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      scl_meta_reg <= 1'b1;
      scl_sync_reg <= 1'b1;
      sda_meta_reg <= 1'b1;
      sda_sync_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
      busy_reg <= 1'b0;
    end
    else
    begin
      scl_meta_reg <= scl_in;
      scl_sync_reg <= scl_meta_reg;
      sda_meta_reg <= sda_in;
      sda_sync_reg <= sda_meta_reg;
      sda_prev_reg <= sda_sync_reg;
      // Falling data with clock high is a START, rising is a STOP
      if (scl_sync_reg && sda_prev_reg && !sda_sync_reg)
        busy_reg <= 1'b1;
      else if (scl_sync_reg && !sda_prev_reg && sda_sync_reg)
        busy_reg <= 1'b0;
    end
  end

  assign scl_s = scl_sync_reg;
  assign sda_s = sda_sync_reg;
  assign bus_free = !busy_reg && scl_sync_reg && sda_sync_reg;

endmodule

// File: tw_master.v
// Two-wire master transmitter: byte-level engine, control, status and
// data registers on a plain strobe port, open-drain bus pins.
// Assumes pull-ups on both lines and a register master that never waits.
//
// Decided for this implementation: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`include "tw_regs.vh"

// What this block does
// - Mode output tracks master transmit, master receive or unaddressed slave.
// - While the completion flag is set, the bus stays suspended.
// - Flag clear with start issues START once the bus is idle.
// - After START the flag sets with status 0x08.
// - Address direction bit selects master transmit or master receive mode.
// - After write address and acknowledge, flag sets with 0x18, 0x20 or 0x38.
// - Data write with flag low is dropped and sets write collision.
// - Flag clear with stop issues a STOP condition.
// - Repeated START reports 0x10 and keeps the bus for any address.
// - In 0x10 a read address is sent and receive mode entered.
// - In 0x18 a plain flag clear sends the loaded byte.
// - In 0x20 the same choices as after an acknowledged address apply.
// - Acknowledged data byte sets the flag with status 0x28.
// - Unacknowledged data byte sets 0x30 with the same choices.
// - Start gives repeated START, stop gives STOP, both give STOP then START.
// - Lost arbitration reports 0x38; clear releases bus or retries START.
module tw_master
#(
  parameter HALF_CYC = `TW_HALF_CYC
)
(
  input wire clk,
  input wire rst,
  input wire [1:0] addr,
  input wire [7:0] wr_data,
  input wire wr_en,
  input wire rd_en,
  output reg [7:0] rd_data,
  input wire scl_in,
  output wire scl_out,
  output wire scl_oe_n,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe_n,
  output wire irq,
  output wire [1:0] mode
);

  localparam S_IDLE = 4'h0;
  localparam S_START = 4'h1;
  localparam S_SLOW = 4'h2;
  localparam S_HOLD = 4'h3;
  localparam S_BLOW = 4'h4;
  localparam S_BHIGH = 4'h5;
  localparam S_RS1 = 4'h6;
  localparam S_RS2 = 4'h7;
  localparam S_P1 = 4'h8;
  localparam S_P2 = 4'h9;
  localparam S_P3 = 4'hA;
  localparam S_LOST = 4'hB;

  localparam [15:0] HALF_LAST = HALF_CYC - 1;
  localparam [15:0] HALF_MID = HALF_CYC / 2;

  wire scl_s;
  wire sda_s;
  wire bus_free;

  reg [3:0] st_reg;
  reg [15:0] tmr_reg;
  reg [3:0] bit_reg;
  reg [7:0] shift_reg;
  reg samp_reg;
  reg rx_reg;
  reg addr_phase_reg;
  reg addr_rd_reg;
  reg rs_reg;
  reg pend_start_reg;
  reg flag_reg;
  reg ack_en_reg;
  reg start_reg;
  reg stop_reg;
  reg wcol_reg;
  reg en_reg;
  reg ie_reg;
  reg [7:0] data_reg;
  reg [7:0] code_reg;
  reg [2:0] presc_reg;
  reg [1:0] mode_reg;
  reg drv_scl;
  reg drv_sda;

  tw_line_mon u_mon
  (
    .clk(clk),
    .rst(rst),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .scl_s(scl_s),
    .sda_s(sda_s),
    .bus_free(bus_free)
  );

  wire ctrl_wr = wr_en && (addr == `TW_ADDR_CTRL);
  wire stat_wr = wr_en && (addr == `TW_ADDR_STAT);
  wire data_wr = wr_en && (addr == `TW_ADDR_DATA);
  wire flag_clr = ctrl_wr && wr_data[`TW_B_FLAG];
  wire cmd = flag_clr && wr_data[`TW_B_EN];
  wire cmd_sta = wr_data[`TW_B_START];
  wire cmd_sto = wr_data[`TW_B_STOP];

  wire half_done = (tmr_reg == HALF_LAST);
  wire tx_bit = (bit_reg < 4'h8) && !rx_reg;
  wire samp = (st_reg == S_BHIGH) && scl_s && (tmr_reg == HALF_MID);
  // A released one read back as zero means another master won
  wire lost = samp && tx_bit && shift_reg[7] && !sda_s;
  wire bend = (st_reg == S_BHIGH) && scl_s && half_done &&
    (bit_reg == 4'h8);
  wire flag_set = ((st_reg == S_SLOW) && half_done) || bend || lost;

  // Bus drive for each state; a one on the line is a release
  always @*
  begin
    drv_scl = 1'b0;
    drv_sda = 1'b0;
    case (st_reg)
      S_START:
        drv_sda = 1'b1;
      S_SLOW:
      begin
        drv_scl = 1'b1;
        drv_sda = 1'b1;
      end
      S_HOLD:
        drv_scl = 1'b1;
      S_BLOW:
      begin
        drv_scl = 1'b1;
        if (bit_reg < 4'h8)
          drv_sda = !rx_reg && !shift_reg[7];
        else
          drv_sda = rx_reg && ack_en_reg;
      end
      S_BHIGH:
      begin
        if (bit_reg < 4'h8)
          drv_sda = !rx_reg && !shift_reg[7];
        else
          drv_sda = rx_reg && ack_en_reg;
      end
      S_RS1:
        drv_scl = 1'b1;
      S_P1:
      begin
        drv_scl = 1'b1;
        drv_sda = 1'b1;
      end
      S_P2:
        drv_sda = 1'b1;
      default:
      begin
        drv_scl = 1'b0;
        drv_sda = 1'b0;
      end
    endcase
  end

  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe_n = !drv_scl;
  assign sda_oe_n = !drv_sda;
  assign irq = flag_reg && ie_reg;
  assign mode = mode_reg;

  // Control, data and status registers seen by software
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      flag_reg <= 1'b0;
      ack_en_reg <= 1'b0;
      start_reg <= 1'b0;
      stop_reg <= 1'b0;
      wcol_reg <= 1'b0;
      en_reg <= 1'b0;
      ie_reg <= 1'b0;
      data_reg <= `TW_DATA_RST;
      presc_reg <= `TW_PRESC_RST;
      rd_data <= 8'h00;
    end
    else
    begin
      // Hardware set wins over a clear in the same cycle
      if (flag_set)
        flag_reg <= 1'b1;
      else if (flag_clr)
        flag_reg <= 1'b0;
      if (ctrl_wr)
      begin
        ack_en_reg <= wr_data[`TW_B_ACK];
        start_reg <= wr_data[`TW_B_START];
        stop_reg <= wr_data[`TW_B_STOP];
        en_reg <= wr_data[`TW_B_EN];
        ie_reg <= wr_data[`TW_B_IE];
      end
      else if ((st_reg == S_P3) && half_done)
        stop_reg <= 1'b0;
      if (stat_wr)
        presc_reg <= wr_data[2:0];
      if (data_wr && !flag_reg)
        wcol_reg <= 1'b1;
      else if (data_wr)
        wcol_reg <= 1'b0;
      if (bend && rx_reg)
        data_reg <= shift_reg;
      else if (data_wr && flag_reg)
        data_reg <= wr_data;
      if (rd_en)
      begin
        if (addr == `TW_ADDR_CTRL)
          rd_data <= {flag_reg, ack_en_reg, start_reg, stop_reg,
            wcol_reg, en_reg, 1'b0, ie_reg};
        else if (addr == `TW_ADDR_STAT)
          rd_data <= {code_reg[7:3], presc_reg};
        else if (addr == `TW_ADDR_DATA)
          rd_data <= data_reg;
        else
          rd_data <= 8'h00;
      end
      else
        rd_data <= 8'h00;
    end
  end

  // Byte engine
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_reg <= S_IDLE;
      tmr_reg <= 16'h0000;
      bit_reg <= 4'h0;
      shift_reg <= 8'h00;
      samp_reg <= 1'b1;
      rx_reg <= 1'b0;
      addr_phase_reg <= 1'b0;
      addr_rd_reg <= 1'b0;
      rs_reg <= 1'b0;
      pend_start_reg <= 1'b0;
      code_reg <= `TW_ST_NONE;
      mode_reg <= `TW_MODE_SLAVE;
    end
    else if (!en_reg)
    begin
      // Disabled: release the bus and forget any pending work, but keep
      // a start from the very write that turns the unit on
      st_reg <= S_IDLE;
      tmr_reg <= 16'h0000;
      pend_start_reg <= cmd && cmd_sta;
      code_reg <= `TW_ST_NONE;
      mode_reg <= `TW_MODE_SLAVE;
    end
    else
    begin
      if (half_done)
        tmr_reg <= 16'h0000;
      else if ((st_reg == S_BHIGH || st_reg == S_RS2 || st_reg == S_P2) &&
        !scl_s)
        tmr_reg <= 16'h0000; // Stretched clock: wait for the line
      else if (st_reg != S_IDLE && st_reg != S_HOLD && st_reg != S_LOST)
        tmr_reg <= tmr_reg + 16'h0001;
      if (cmd && cmd_sta && (st_reg == S_IDLE))
        pend_start_reg <= 1'b1;
      case (st_reg)
        S_IDLE:
        begin
          tmr_reg <= 16'h0000;
          if (pend_start_reg && bus_free)
          begin
            st_reg <= S_START;
            pend_start_reg <= 1'b0;
            rs_reg <= 1'b0;
          end
        end
        S_START:
          if (half_done)
            st_reg <= S_SLOW;
        S_SLOW:
          if (half_done)
          begin
            st_reg <= S_HOLD;
            addr_phase_reg <= 1'b1;
            if (rs_reg)
              code_reg <= `TW_ST_RSTART;
            else
              code_reg <= `TW_ST_START;
          end
        S_HOLD:
          if (cmd && !flag_set)
          begin
            tmr_reg <= 16'h0000;
            if (cmd_sto)
            begin
              st_reg <= S_P1;
              pend_start_reg <= cmd_sta;
            end
            else if (cmd_sta)
              st_reg <= S_RS1;
            else
            begin
              st_reg <= S_BLOW;
              bit_reg <= 4'h0;
              shift_reg <= data_reg;
              addr_rd_reg <= data_reg[0];
              rx_reg <= !addr_phase_reg && (mode_reg == `TW_MODE_MR);
            end
          end
        S_BLOW:
          if (half_done)
            st_reg <= S_BHIGH;
        S_BHIGH:
        begin
          if (lost)
          begin
            st_reg <= S_LOST;
            code_reg <= `TW_ST_ARB;
            mode_reg <= `TW_MODE_SLAVE;
          end
          else if (samp)
            samp_reg <= sda_s;
          if (!lost && scl_s && half_done)
          begin
            if (bit_reg == 4'h8)
            begin
              st_reg <= S_HOLD;
              addr_phase_reg <= 1'b0;
              if (addr_phase_reg && addr_rd_reg)
              begin
                mode_reg <= `TW_MODE_MR;
                code_reg <= samp_reg ? `TW_ST_AR_NACK : `TW_ST_AR_ACK;
              end
              else if (addr_phase_reg)
              begin
                mode_reg <= `TW_MODE_MT;
                code_reg <= samp_reg ? `TW_ST_AW_NACK : `TW_ST_AW_ACK;
              end
              else if (rx_reg)
                code_reg <= ack_en_reg ? `TW_ST_DR_ACK : `TW_ST_DR_NACK;
              else
                code_reg <= samp_reg ? `TW_ST_DT_NACK : `TW_ST_DT_ACK;
            end
            else
            begin
              st_reg <= S_BLOW;
              bit_reg <= bit_reg + 4'h1;
              shift_reg <= {shift_reg[6:0], samp_reg};
            end
          end
        end
        S_RS1:
          if (half_done)
            st_reg <= S_RS2;
        S_RS2:
          if (scl_s && half_done)
          begin
            st_reg <= S_START;
            rs_reg <= 1'b1;
          end
        S_P1:
          if (half_done)
            st_reg <= S_P2;
        S_P2:
          if (scl_s && half_done)
            st_reg <= S_P3;
        S_P3:
          if (half_done)
          begin
            st_reg <= S_IDLE;
            code_reg <= `TW_ST_NONE;
            mode_reg <= `TW_MODE_SLAVE;
          end
        S_LOST:
          if (cmd && !flag_set)
          begin
            st_reg <= S_IDLE;
            pend_start_reg <= cmd_sta;
            code_reg <= `TW_ST_NONE;
          end
        default:
          st_reg <= S_IDLE;
      endcase
    end
  end

endmodule

// File: tw_master_properties.sv
// Checker for the two-wire master: register port and bus pin timing.
// Sees only the top ports; bound to every tw_master instance.
`timescale 1ns/1ps
module tw_master_properties
#(
  parameter HALF_CYC = 4
)
(
  input wire clk,
  input wire rst,
  input wire [1:0] addr,
  input wire [7:0] wr_data,
  input wire wr_en,
  input wire rd_en,
  input wire [7:0] rd_data,
  input wire scl_in,
  input wire scl_out,
  input wire scl_oe_n,
  input wire sda_in,
  input wire sda_out,
  input wire sda_oe_n,
  input wire irq,
  input wire [1:0] mode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  reg [15:0] lo_cnt;
  reg [15:0] hi_cnt;
  // Low and high phase lengths; hi_cnt spans START and STOP holds
  always @(posedge clk or posedge rst)
    if (rst)
    begin
      lo_cnt <= 16'h0;
      hi_cnt <= 16'h0;
    end
    else
    begin
      lo_cnt <= scl_oe_n ? 16'h0 : lo_cnt + 16'h1;
      hi_cnt <= (scl_oe_n && !sda_oe_n) ? hi_cnt + 16'h1 : 16'h0;
    end
  chk_rd_one_cycle: assert property (!$past(rd_en) |-> rd_data == 8'h00)
    else $error("read data outside its cycle");
  chk_unmapped_zero: assert property
    (rd_en && addr == 2'h3 |=> rd_data == 8'h00)
    else $error("unmapped read not zero");
  chk_pins_open: assert property (scl_out == 1'b0 && sda_out == 1'b0)
    else $error("pin output driven high");
  chk_flag_holds_bus: assert property (
    irq && $past(irq) && $past(irq, 2) |-> $stable(scl_oe_n) && $stable(sda_oe_n))
    else $error("bus moved while flag set");
  chk_start_bus_free: assert property (
    $fell(sda_oe_n) && scl_oe_n |-> $past(scl_in) && $past(sda_in))
    else $error("start on busy bus");
  chk_hold_len: assert property (hi_cnt <= HALF_CYC + 8)
    else $error("start or stop hold too long");
  chk_scl_low_time: assert property (
    $rose(scl_oe_n) |-> $past(lo_cnt) >= HALF_CYC - 1)
    else $error("clock low phase too short");
  chk_stop_no_flag: assert property (
    $rose(sda_oe_n) && scl_oe_n && $past(scl_oe_n) |-> !irq)
    else $error("stop with flag set");
  cover property ($rose(irq));
  cover property ($fell(sda_oe_n) && scl_oe_n);
  cover property ($rose(sda_oe_n) && scl_oe_n && $past(scl_oe_n));
endmodule

bind tw_master tw_master_properties #(.HALF_CYC(HALF_CYC)) i_props (
  .clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
  .rd_en(rd_en), .rd_data(rd_data), .scl_in(scl_in), .scl_out(scl_out),
  .scl_oe_n(scl_oe_n), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe_n(sda_oe_n), .irq(irq), .mode(mode));

// File: tw_slave_model.sv
// Behavioural slave receiver on the two-wire bus.
// Assumes pull-ups; it only ever pulls the data line low.
`timescale 1ns/1ps
module tw_slave_model
(
  input wire scl,
  input wire sda,
  input wire nack,
  output reg sda_low,
  output reg [7:0] rx_byte
);
  integer n;
  reg [7:0] sh;
  initial
  begin
    n = 0;
    sh = 8'h00;
    sda_low = 1'b0;
    rx_byte = 8'h00;
  end
  // Start or repeated start restarts the bit count
  // Look a moment later: data and clock may fall in one time step
  always @(negedge sda)
    #1 if (scl && !sda)
      n = 0;
  always @(posedge scl)
  begin
    if (n < 8)
      sh = {sh[6:0], sda};
    n = n + 1;
    if (n == 8)
      rx_byte = sh;
  end
  // Acknowledge slot; released line floats high afterwards
  always @(negedge scl)
    if (n == 8)
      sda_low <= !nack;
    else if (n == 9)
    begin
      sda_low <= 1'b0;
      n = 0;
    end
endmodule

// File: tw_master_tb.sv
// Self-checking bench for tw_master with a slave model on the bus.
// Assumes HALF_CYC of 4 to keep each byte short.
`timescale 1ns/1ps
module tw_master_tb;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg [1:0] addr = 2'h0;
  reg [7:0] wr_data = 8'h00;
  reg wr_en = 1'b0;
  reg rd_en = 1'b0;
  reg nack = 1'b0;
  reg arb_low = 1'b0;
  reg [7:0] v;
  wire [7:0] rd_data;
  wire scl_out;
  wire scl_oe_n;
  wire sda_out;
  wire sda_oe_n;
  wire irq;
  wire [1:0] mode;
  wire sl_low;
  wire [7:0] rx_byte;
  wire scl_w = scl_oe_n ? 1'b1 : scl_out;
  wire sda_w = (sda_oe_n ? 1'b1 : sda_out) & ~sl_low & ~arb_low;
  integer bad_count = 0;
  integer n_checks = 0;
  integer cyc = 0;
  always #4 clk = ~clk;
  tw_master #(.HALF_CYC(4)) i_tw_master (.clk(clk), .rst(rst),
    .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .scl_in(scl_w), .scl_out(scl_out),
    .scl_oe_n(scl_oe_n), .sda_in(sda_w), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .irq(irq), .mode(mode));
  tw_slave_model i_tw_slave_model (.scl(scl_w), .sda(sda_w), .nack(nack),
    .sda_low(sl_low), .rx_byte(rx_byte));
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task chk(input [8*8:1] nm, input [7:0] e, input [7:0] g);
    begin
      n_checks = n_checks + 1;
      if (g !== e)
      begin
        bad_count = bad_count + 1;
        $display("wrong value %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task wr(input [1:0] a, input [7:0] d);
    begin
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
      // One idle edge so a following strobe is never assigned twice
      @(posedge clk);
    end
  endtask
  // Read data stand only in the cycle after the strobe
  task rd(input [1:0] a, output [7:0] d);
    begin
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1 d = rd_data;
      @(posedge clk);
    end
  endtask
  task rdc(input [1:0] a, input [8*8:1] nm, input [7:0] e);
    begin
      rd(a, v);
      chk(nm, e, v);
    end
  endtask
  task stat(input [7:0] e);
    begin
      rd(2'h1, v);
      chk("status", e, v & 8'hF8);
    end
  endtask
  task wait_flag;
    integer i;
    begin
      i = 0;
      @(posedge clk);
      while (irq !== 1'b1 && i < 400)
      begin
        @(posedge clk);
        i = i + 1;
      end
      chk("irq", 8'h01, {7'h0, irq});
    end
  endtask
  task go(input [7:0] c, input [7:0] e);
    begin
      wr(2'h0, c);
      wait_flag;
      stat(e);
    end
  endtask
  task send(input [7:0] b, input [7:0] e);
    begin
      wr(2'h2, b);
      go(8'h85, e);
    end
  endtask
  task t_reset;
    begin
      rdc(2'h0, "ctrl", 8'h00);
      stat(8'hF8);
      rdc(2'h2, "data", 8'hFF);
      rdc(2'h3, "unmapped", 8'h00);
      chk("mode", 8'h00, {6'h0, mode});
      $display("test reset done");
    end
  endtask
  task t_collision;
    begin
      wr(2'h2, 8'h5A);
      rdc(2'h0, "ctrl", 8'h08);
      rdc(2'h2, "data", 8'hFF);
      $display("test collision done");
    end
  endtask
  task t_write;
    integer i;
    begin
      go(8'hA5, 8'h08);
      send(8'hA6, 8'h18);
      chk("mode", 8'h01, {6'h0, mode});
      chk("rx", 8'hA6, rx_byte);
      send(8'h3C, 8'h28);
      chk("rx", 8'h3C, rx_byte);
      nack <= 1'b1;
      send(8'h55, 8'h30);
      go(8'hA5, 8'h10);
      send(8'hA6, 8'h20);
      nack <= 1'b0;
      send(8'hC3, 8'h28);
      go(8'hA5, 8'h10);
      send(8'hA7, 8'h40);
      chk("mode", 8'h02, {6'h0, mode});
      go(8'hB5, 8'h08);
      wr(2'h0, 8'h95);
      v = 8'h10;
      for (i = 0; i < 50 && v[4]; i = i + 1)
        rd(2'h0, v);
      chk("ctrl", 8'h05, v);
      stat(8'hF8);
      chk("mode", 8'h00, {6'h0, mode});
      $display("test write done");
    end
  endtask
  task t_arb;
    begin
      go(8'hA5, 8'h08);
      wr(2'h2, 8'hA6);
      arb_low <= 1'b1;
      go(8'h85, 8'h38);
      arb_low <= 1'b0;
      wr(2'h0, 8'h85);
      repeat (4) @(posedge clk);
      chk("mode", 8'h00, {6'h0, mode});
      chk("oe_n", 8'h03, {6'h0, scl_oe_n, sda_oe_n});
      $display("test arbitration done");
    end
  endtask
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      bad_count = bad_count + 1;
      end_of_test;
    end
  end
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset;
    t_collision;
    t_write;
    t_arb;
    end_of_test;
  end
endmodule
